/* File: design/stom_consts.svh */
// Summary of operation
// - Pulse width fault if pause below 90%
// - Selection under enable: torque off plus diagnostic
// - Setting picks error or warning for that
// - Warning clears itself when enable drops
// - Error stays latched until operator clear
// - Every diagnostic enters the numbers list
// - Selected when both inputs read 0, or A alone in single channel
// - Torque removed at once, axis coasts
// - Brake control follows torque-off, never separately
// - Lone channel: other must select first
// - Channels may disagree at most 1 s
// - Torque-off and brake state readable
// - One or two channel selection, variant check
// - Brake switched off over two channels
// - Energize-to-clamp brake rejected
// - Outputs tested online with test pulses
// - Panel shows torque-off while brake active
// - Valid test pulse lasts 20 us or more
// - Deselected time per channel, 1 hour limit
// - One missed pulse forgiven by next 8
`ifndef STOM_CONSTS_SVH
`define STOM_CONSTS_SVH
// Clock rate
`define CLK_MHZ 125
// Shortest valid test pulse
`define PULSE_MIN_US 20
`define PULSE_MIN_CYC (`PULSE_MIN_US * `CLK_MHZ)
// Longest low still taken as a test pulse
`define PULSE_MAX_US 1000
`define PULSE_MAX_CYC (`PULSE_MAX_US * `CLK_MHZ)
// Pause to pulse ratio: pause >= 90% of period
`define RATIO_PAUSE 9
// Pulses needed to forgive one miss
`define GOOD_PULSES 8
// Channel disagreement tolerance
`define DISC_S 1
`define DISC_CYC (`DISC_S * 1000000 * `CLK_MHZ)
// Deselected time allowed without a pulse
`define IVL_H 1
`define IVL_CYC (64'd3600 * 64'd1000000 * `CLK_MHZ * `IVL_H)
// Output test: period and off time
`define OTEST_PER_MS 1000
`define OTEST_PER_CYC (`OTEST_PER_MS * 1000 * `CLK_MHZ)
`define OTEST_LEN_US 500
`define OTEST_LEN_CYC (`OTEST_LEN_US * `CLK_MHZ)
// Diagnostic list output depth
`define DIAG_N 8
`endif

/* File: design/stom_pkg.sv */
`default_nettype none
package stom_pkg;
	// Static configuration
	typedef struct packed {
		logic single_channel;   // Selection over channel A alone
		logic single_forbidden; // Variant rejects single channel
		logic error_mode;       // 1: fatal error, 0: warning
		logic brake_option;     // Brake capable option fitted
		logic brake_present;    // Holding brake connected
		logic brake_clamp_on;   // Brake clamps when energised
	} config_t;
	// Operating status
	typedef struct packed {
		logic torque_off;
		logic brake_active;
		logic sel_a;
		logic sel_b;
		logic output_test;
	} status_t;
	// Diagnostics, latched except notice, warning and config fault
	typedef struct packed {
		logic safety_active_notice;
		logic select_under_enable_warning;
		logic select_under_enable_error;
		logic test_pulse_width_fault;
		logic selection_check_fault;
		logic switchoff_channel_fault;
		logic test_pulse_interval_fault;
		logic safety_config_fault;
	} diag_t;
	// Codes for the diagnostic list, same order as diag_t
	typedef enum logic [2:0] {
		DG_CONFIG, DG_INTERVAL, DG_SWITCHOFF, DG_SELCHECK,
		DG_WIDTH, DG_ERROR, DG_WARNING, DG_NOTICE
	} diag_code_t;
	// Output test sequencer
	typedef enum logic [1:0] {OT_WAIT, OT_OFF, OT_CHECK} otest_t;
endpackage
`default_nettype wire

/* File: design/sel_channel_monitor.sv */
`include "stom_consts.svh"
`default_nettype none
module sel_channel_monitor
	import stom_pkg::*;
#(
	parameter logic [16:0] PULSE_MAX = 17'(`PULSE_MAX_CYC),
	parameter logic [39:0] IVL_CYC   = 40'(`IVL_CYC)
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic arst_n,
	// Selection pin, low active
	input  wire logic sel_n,
	input  wire logic clear,
	// Results
	output logic      level_q,
	output logic      held_q,
	output logic      pulse_q,
	output logic      width_fault_q,
	output logic      ivl_fault_q
);
	logic        s1_q, s2_q;  // Synchroniser stages
	logic [16:0] low_q;       // Low time, saturating
	logic [20:0] high_q;      // Pause time, saturating
	logic [39:0] ivl_q;       // Deselected time since last pulse
	logic        seen_q;      // A pause has been measured
	logic        missed_q;    // One pulse missed, on probation
	logic [3:0]  good_q;      // Pulses since the miss
	// Decode of edges and checks
	wire rise     = !level_q && s2_q;
	wire valid    = rise && (low_q >= 17'(`PULSE_MIN_CYC)) && !held_q;
	wire ratio_ng = seen_q && (high_q < 21'(`RATIO_PAUSE) * {4'h0, low_q});
	wire ivl_end  = s2_q && (ivl_q >= IVL_CYC - 40'h1);
	wire forgiven = missed_q && (good_q == 4'(`GOOD_PULSES - 1));
	// Two-stage synchroniser, second stage read only
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			s1_q    <= 1'b1;
			s2_q    <= 1'b1;
			level_q <= 1'b1;
		end
		else
		begin
			s1_q    <= sel_n;
			s2_q    <= s1_q;
			level_q <= s2_q;
		end
	// Low and pause timers
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			low_q  <= 17'h0;
			high_q <= 21'h0;
			seen_q <= 1'b0;
			held_q <= 1'b0;
		end
		else
		begin
			low_q  <= s2_q ? 17'h0 : (low_q == PULSE_MAX ? low_q : low_q + 17'h1);
			high_q <= rise ? 21'h0 : (!s2_q || &high_q ? high_q : high_q + 21'h1);
			held_q <= !s2_q && (low_q >= PULSE_MAX - 17'h1);
			if (rise)
				seen_q <= 1'b1;
		end
	// Pulse strobe and width fault
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			pulse_q       <= 1'b0;
			width_fault_q <= 1'b0;
		end
		else
		begin
			pulse_q       <= valid;
			width_fault_q <= (valid && ratio_ng) || (width_fault_q && !clear);
		end
	// Interval watch with one forgiven miss
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			ivl_q       <= 40'h0;
			missed_q    <= 1'b0;
			good_q      <= 4'h0;
			ivl_fault_q <= 1'b0;
		end
		else
		begin
			// Time adds up only while deselected
			if (valid || ivl_end)
				ivl_q <= 40'h0;
			else if (s2_q)
				ivl_q <= ivl_q + 40'h1;
			if (ivl_end)
				missed_q <= 1'b1;
			else if (valid && forgiven)
				missed_q <= 1'b0;
			if (ivl_end || forgiven && valid)
				good_q <= 4'h0;
			else if (valid && missed_q)
				good_q <= good_q + 4'h1;
			ivl_fault_q <= (ivl_end && missed_q) || (ivl_fault_q && !clear);
		end
	// Checks
	property p_pulse_min;
		@(posedge mclk) disable iff (!arst_n)
		pulse_q |-> $past(low_q) >= 17'(`PULSE_MIN_CYC);
	endproperty
	a_pulse_min: assert property (p_pulse_min) else $error("short pulse taken");
	property p_ivl_fault;
		@(posedge mclk) disable iff (!arst_n)
		ivl_end && missed_q |=> ivl_fault_q;
	endproperty
	a_ivl_fault: assert property (p_ivl_fault) else $error("second miss not flagged");
endmodule
`default_nettype wire

/* File: design/safe_torque_off_selection_monitor.sv */
`include "stom_consts.svh"
`default_nettype none
module safe_torque_off_selection_monitor
	import stom_pkg::*;
#(
	parameter logic [16:0] PULSE_MAX  = 17'(`PULSE_MAX_CYC),
	parameter logic [39:0] IVL_CYC    = 40'(`IVL_CYC),
	parameter logic [26:0] DISC_CYC   = 27'(`DISC_CYC),
	parameter logic [27:0] OTEST_PER  = 28'(`OTEST_PER_CYC),
	parameter logic [16:0] OTEST_LEN  = 17'(`OTEST_LEN_CYC)
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Selection inputs from the safety unit, low active
	input  wire logic        sel_a_n,
	input  wire logic        sel_b_n,
	// Drive side
	input  wire logic        drive_enable,
	input  wire config_t     cfg,
	input  wire logic        clear_diag,
	// Read-back of switch-off paths, high while energised
	input  wire logic [3:0]  switch_fb,
	// Power stage and brake, high enables torque or releases brake
	output logic             torque_en_a_q,
	output logic             torque_en_b_q,
	output logic             brake_rel_a_q,
	output logic             brake_rel_b_q,
	// Status and diagnostics
	output status_t          status_q,
	output diag_t            diag_q,
	output logic             panel_torque_off_q,
	output diag_code_t       diag_num_q,
	output logic             diag_strobe_q
);
	// Channel results
	logic lvl_a, lvl_b;        // Synchronised levels
	logic held_a, held_b;      // Held low beyond a pulse
	logic pls_a, pls_b;        // Valid pulse strobes
	logic wf_a, wf_b;          // Width faults
	logic if_a, if_b;          // Interval faults
	// Selection tracking
	logic        sel_prev_q;   // Selection one cycle ago
	logic [1:0]  lone_q;       // Channel that selected alone
	logic [26:0] disc_q;       // Disagreement timer
	logic        selchk_q;     // Selection check fault
	logic        warn_q;       // Warning flag
	logic        err_q;        // Error flag
	// Output test
	otest_t      ot_q;         // Test sequencer state
	logic [27:0] ot_cnt_q;     // Period and off-time counter
	logic        swoff_q;      // Switch-off channel fault
	// Diagnostic list feeder
	logic [7:0]  diag_prev_q;  // Flags seen last cycle
	logic [7:0]  pend_q;       // Entries waiting for the list

	// Both channel monitors
	sel_channel_monitor #(
		.PULSE_MAX (PULSE_MAX),
		.IVL_CYC   (IVL_CYC)
	) u_ch_a (
		.mclk          (mclk),
		.arst_n        (arst_n),
		.sel_n         (sel_a_n),
		.clear         (clear_diag),
		.level_q       (lvl_a),
		.held_q        (held_a),
		.pulse_q       (pls_a),
		.width_fault_q (wf_a),
		.ivl_fault_q   (if_a)
	);
	sel_channel_monitor #(
		.PULSE_MAX (PULSE_MAX),
		.IVL_CYC   (IVL_CYC)
	) u_ch_b (
		.mclk          (mclk),
		.arst_n        (arst_n),
		.sel_n         (sel_b_n),
		.clear         (clear_diag),
		.level_q       (lvl_b),
		.held_q        (held_b),
		.pulse_q       (pls_b),
		.width_fault_q (wf_b),
		.ivl_fault_q   (if_b)
	);

	// Selection decode
	wire single    = cfg.single_channel;
	wire sel_w     = single ? !lvl_a : (!lvl_a && !lvl_b);
	wire sel_rise  = sel_w && !sel_prev_q;
	wire under_en  = sel_rise && drive_enable;
	// Configuration faults
	wire cfg_bad   = (single && cfg.single_forbidden)
	               || (cfg.brake_option && cfg.brake_present && cfg.brake_clamp_on);
	// Brake control exists only on the brake option with a brake
	wire brake_ok  = cfg.brake_option && cfg.brake_present;
	// Any fatal condition that must also remove torque
	wire fatal     = diag_q.test_pulse_width_fault || diag_q.selection_check_fault
	               || diag_q.switchoff_channel_fault || diag_q.test_pulse_interval_fault
	               || diag_q.safety_config_fault || diag_q.select_under_enable_error;
	wire off_w     = sel_w || fatal || cfg_bad;
	// Disagreement and lone channel checks, dual wiring only
	wire disagree  = !single && (held_a ^ held_b);
	wire disc_end  = disagree && (disc_q >= DISC_CYC - 27'h1);
	wire lone_lost = !single && (lone_q != 2'b00) && !held_a && !held_b;
	// Output test timing
	wire ot_off    = (ot_q == OT_OFF);
	wire ot_done   = ot_off && (ot_cnt_q >= {11'h0, OTEST_LEN} - 28'h1);
	wire ot_due    = (ot_q == OT_WAIT) && (ot_cnt_q >= OTEST_PER - 28'h1);
	wire fb_stuck  = |switch_fb;
	// Current flag vector and its new entries
	wire [7:0] diag_v   = diag_q;
	wire [7:0] new_diag = diag_v & ~diag_prev_q;
	wire [7:0] pick     = pend_q & (~pend_q + 8'h1);

	// Selection history
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
			sel_prev_q <= 1'b0;
		else
			sel_prev_q <= sel_w;

	// Lone channel memory
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
			lone_q <= 2'b00;
		else if (held_a && held_b || lone_lost || single)
			lone_q <= 2'b00;
		else if (lone_q == 2'b00)
			lone_q <= {held_b, held_a};

	// Disagreement timer
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
			disc_q <= 27'h0;
		else if (!disagree || disc_end)
			disc_q <= 27'h0;
		else
			disc_q <= disc_q + 27'h1;

	// Selection check fault, set wins over clear
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
			selchk_q <= 1'b0;
		else
			selchk_q <= disc_end || lone_lost || (selchk_q && !clear_diag);

	// Selection under enable: warning or error
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			warn_q <= 1'b0;
			err_q  <= 1'b0;
		end
		else
		begin
			// Warning drops by itself once enable is gone
			warn_q <= (under_en && !cfg.error_mode) || (warn_q && drive_enable);
			// Error waits for the operator
			err_q  <= (under_en && cfg.error_mode) || (err_q && !clear_diag);
		end

	// Output test sequencer
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			ot_q     <= OT_WAIT;
			ot_cnt_q <= 28'h0;
			swoff_q  <= 1'b0;
		end
		else
		begin
			case (ot_q)
				// Count the test period
				OT_WAIT:
				begin
					ot_cnt_q <= ot_due ? 28'h0 : ot_cnt_q + 28'h1;
					if (ot_due)
						ot_q <= OT_OFF;
				end
				// Outputs held off for a short time
				OT_OFF:
				begin
					ot_cnt_q <= ot_done ? 28'h0 : ot_cnt_q + 28'h1;
					if (ot_done)
						ot_q <= OT_CHECK;
				end
				// Every path must read back off
				OT_CHECK:
					ot_q <= OT_WAIT;
				default:
					ot_q <= OT_WAIT;
			endcase
			swoff_q <= (ot_q == OT_CHECK && fb_stuck) || (swoff_q && !clear_diag);
		end

	// Power stage and brake channels
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			torque_en_a_q <= 1'b0;
			torque_en_b_q <= 1'b0;
			brake_rel_a_q <= 1'b0;
			brake_rel_b_q <= 1'b0;
		end
		else
		begin
			// Torque removed at once; no ramp, the axis coasts
			torque_en_a_q <= !off_w && !ot_off;
			torque_en_b_q <= !off_w && !ot_off;
			// Brake falls with torque, over two independent paths
			brake_rel_a_q <= brake_ok && !off_w && !ot_off;
			brake_rel_b_q <= brake_ok && !off_w && !ot_off;
		end

	// Status word and front panel
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			status_q           <= '0;
			panel_torque_off_q <= 1'b0;
		end
		else
		begin
			status_q.torque_off   <= off_w;
			status_q.brake_active <= off_w && brake_ok;
			status_q.sel_a        <= !lvl_a;
			status_q.sel_b        <= !lvl_b;
			status_q.output_test  <= ot_off;
			// Brake control never runs alone, so torque-off is shown
			panel_torque_off_q    <= off_w;
		end

	// Diagnostic flags
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
			diag_q <= '0;
		else
		begin
			diag_q.safety_active_notice        <= sel_w;
			diag_q.select_under_enable_warning <= warn_q;
			diag_q.select_under_enable_error   <= err_q;
			diag_q.test_pulse_width_fault      <= wf_a || wf_b;
			diag_q.selection_check_fault       <= selchk_q;
			diag_q.switchoff_channel_fault     <= swoff_q;
			diag_q.test_pulse_interval_fault   <= if_a || if_b;
			diag_q.safety_config_fault         <= cfg_bad;
		end

	// Queue each new flag and emit one list entry per cycle
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			diag_prev_q   <= 8'h00;
			pend_q        <= 8'h00;
			diag_num_q    <= DG_CONFIG;
			diag_strobe_q <= 1'b0;
		end
		else
		begin
			diag_prev_q   <= diag_v;
			// A new entry wins over the one being taken
			pend_q        <= (pend_q & ~pick) | new_diag;
			diag_strobe_q <= |pend_q;
			if (|pend_q)
				diag_num_q <= diag_code_t'($clog2(pick));
		end

	// Checks
	sequence s_selected;
		sel_w && !fatal;
	endsequence
	sequence s_all_off;
		!torque_en_a_q && !torque_en_b_q && !brake_rel_a_q && !brake_rel_b_q;
	endsequence
	property p_sel_off;
		@(posedge mclk) disable iff (!arst_n)
		s_selected |=> s_all_off;
	endproperty
	a_sel_off: assert property (p_sel_off) else $error("torque kept on select");

	property p_both_low;
		@(posedge mclk) disable iff (!arst_n)
		!single && lvl_a && !fatal && !cfg_bad && !ot_off |=> torque_en_a_q;
	endproperty
	a_both_low: assert property (p_both_low) else $error("one low channel selected");

	property p_brake_pair;
		@(posedge mclk) disable iff (!arst_n)
		brake_rel_a_q == brake_rel_b_q && (!brake_rel_a_q || torque_en_a_q);
	endproperty
	a_brake_pair: assert property (p_brake_pair) else $error("brake not tied");

	property p_mode;
		@(posedge mclk) disable iff (!arst_n)
		under_en |=> (cfg.error_mode ? err_q : warn_q) ##1
			(cfg.error_mode ? diag_q.select_under_enable_error
			: diag_q.select_under_enable_warning);
	endproperty
	a_mode: assert property (p_mode) else $error("wrong under-enable flag");

	property p_warn_clear;
		@(posedge mclk) disable iff (!arst_n)
		warn_q && !drive_enable |=> !warn_q;
	endproperty
	a_warn_clear: assert property (p_warn_clear) else $error("warning stuck");

	property p_err_hold;
		@(posedge mclk) disable iff (!arst_n)
		err_q && !clear_diag |=> err_q;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error lost");

	property p_list;
		@(posedge mclk) disable iff (!arst_n)
		$rose(diag_q.test_pulse_width_fault) |-> ##[1:9] diag_strobe_q && diag_num_q == DG_WIDTH;
	endproperty
	a_list: assert property (p_list) else $error("entry missing");

	property p_disc;
		@(posedge mclk) disable iff (!arst_n)
		disc_end |=> selchk_q ##1 diag_q.selection_check_fault;
	endproperty
	a_disc: assert property (p_disc) else $error("disagreement unflagged");

	property p_cfg;
		@(posedge mclk) disable iff (!arst_n)
		cfg.brake_option && cfg.brake_present && cfg.brake_clamp_on |=> !brake_rel_a_q;
	endproperty
	a_cfg: assert property (p_cfg) else $error("clamp brake accepted");

	property p_panel;
		@(posedge mclk) disable iff (!arst_n)
		status_q.brake_active |-> panel_torque_off_q && status_q.torque_off;
	endproperty
	a_panel: assert property (p_panel) else $error("panel wrong");
endmodule
`default_nettype wire

/* File: bench/sel_unit_model.sv */
`default_nettype none
module sel_unit_model (
	// Clock
	input  wire logic mclk,
	// Selection pins, low active
	output logic      sel_a_n,
	output logic      sel_b_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Test pulse low time, above the 2500 cycle minimum
	localparam int PULSE_LOW = 2600;
	// Both channels deselected at power up
	initial
	begin
		sel_a_n = 1'b1;
		sel_b_n = 1'b1;
	end
	// Set both pins just after a falling edge, then hold them
	task automatic hold(input logic a_n, input logic b_n, input int cyc);
		@(negedge mclk);
		sel_a_n = a_n;
		sel_b_n = b_n;
		repeat (cyc) @(negedge mclk);
	endtask
	// Test pulse on channel A followed by the given pause
	task automatic pulse_a(input int pause);
		hold(1'b0, 1'b1, PULSE_LOW);
		hold(1'b1, 1'b1, pause);
	endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import stom_pkg::*;
	// Stimulus and observed outputs
	logic       mclk, arst_n, drive_enable, clear_diag;
	logic       sel_a_n, sel_b_n;
	logic [3:0] stuck;        // Forced read-back faults
	logic [3:0] switch_fb;    // Power stage read-back
	logic       ten_a, ten_b, brl_a, brl_b, panel, strobe;
	config_t    cfg;
	status_t    status;
	diag_t      diag;
	diag_code_t dnum;
	logic [7:0] logged;       // Codes seen in the diagnostic list
	int         err_total, n_compared, cyc;
	// Free running clock, 8 ns period
	initial mclk = 1'b0;
	always #4 mclk = ~mclk;
	// Read-back follows the switch-off paths unless a fault is forced
	assign switch_fb = {ten_a, ten_b, brl_a, brl_b} | stuck;
	sel_unit_model m (.mclk(mclk), .sel_a_n(sel_a_n), .sel_b_n(sel_b_n));
	safe_torque_off_selection_monitor #(
		.PULSE_MAX(17'd3000), .IVL_CYC(40'd15000), .DISC_CYC(27'd5000),
		.OTEST_PER(28'd10000), .OTEST_LEN(17'd100)
	) uut (
		.mclk(mclk), .arst_n(arst_n), .sel_a_n(sel_a_n), .sel_b_n(sel_b_n),
		.drive_enable(drive_enable), .cfg(cfg), .clear_diag(clear_diag),
		.switch_fb(switch_fb), .torque_en_a_q(ten_a), .torque_en_b_q(ten_b),
		.brake_rel_a_q(brl_a), .brake_rel_b_q(brl_b), .status_q(status),
		.diag_q(diag), .panel_torque_off_q(panel), .diag_num_q(dnum),
		.diag_strobe_q(strobe)
	);
	// Record every entry of the diagnostic list
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			logged <= 8'h00;
		else if (strobe === 1'b1)
			logged[dnum] <= 1'b1;
	end
	// Verdict and end of run
	task automatic wrap_up();
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Hang guard
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			err_total++;
			wrap_up();
		end
	end
	// Compare one observed value with its expectation
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Wait a number of falling edges
	task automatic wt(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Reset for 5 cycles with a new static configuration
	task automatic do_reset(input logic [5:0] c);
		@(negedge mclk);
		arst_n = 1'b0;
		cfg = config_t'(c);
		drive_enable = 1'b0;
		clear_diag = 1'b0;
		stuck = 4'h0;
		wt(5);
		arst_n = 1'b1;
		wt(10);
	endtask
	// One cycle operator clear
	task automatic clear_pulse();
		clear_diag = 1'b1;
		wt(1);
		clear_diag = 1'b0;
		wt(10);
	endtask
	// Main sequence
	initial
	begin
		arst_n = 1'b0;
		drive_enable = 1'b0;
		clear_diag = 1'b0;
		stuck = 4'h0;
		cfg = config_t'(6'b000110);
		err_total = 0;
		n_compared = 0;
		cyc = 0;
		// Plain selection, dual channel, brake fitted
		do_reset(6'b000110);
		chk("torque_on", {ten_a, ten_b, brl_a, brl_b}, 8'h0f);
		chk("diag_idle", diag, 8'h00);
		m.hold(1'b0, 1'b1, 100);
		chk("lone_a_no_stop", ten_a, 1'b1);
		m.hold(1'b0, 1'b0, 0);
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk("sync_delay", ten_a, 1'b1);
		@(posedge mclk);
		@(negedge mclk);
		chk("stop_paths", {ten_a, ten_b, brl_a, brl_b}, 8'h00);
		chk("status", {status.torque_off, status.brake_active}, 8'h03);
		chk("panel", panel, 1'b1);
		chk("sel_ab", {status.sel_a, status.sel_b}, 8'h03);
		wt(10);
		chk("notice", diag.safety_active_notice, 1'b1);
		chk("logged_notice", logged[DG_NOTICE], 1'b1);
		chk("no_selchk", diag.selection_check_fault, 1'b0);
		m.hold(1'b1, 1'b1, 20);
		chk("resume", {ten_a, brl_a, status.torque_off}, 8'h06);
		// Lone channel released before the other selects
		do_reset(6'b000110);
		m.hold(1'b0, 1'b1, 3500);
		m.hold(1'b1, 1'b1, 20);
		chk("selchk_lone", diag.selection_check_fault, 1'b1);
		chk("selchk_off", ten_a, 1'b0);
		chk("logged_selchk", logged[DG_SELCHECK], 1'b1);
		// Disagreement time limit
		do_reset(6'b000110);
		m.hold(1'b0, 1'b1, 4900);
		chk("disc_early", diag.selection_check_fault, 1'b0);
		m.hold(1'b0, 1'b1, 3200);
		chk("disc_late", diag.selection_check_fault, 1'b1);
		m.hold(1'b1, 1'b1, 10);
		// Selection under enable reported as warning
		do_reset(6'b000110);
		drive_enable = 1'b1;
		m.hold(1'b0, 1'b0, 10);
		chk("warn_set", {diag.select_under_enable_warning, diag.select_under_enable_error},
			8'h02);
		chk("warn_stop", ten_a, 1'b0);
		chk("logged_warn", logged[DG_WARNING], 1'b1);
		drive_enable = 1'b0;
		wt(5);
		chk("warn_gone", diag.select_under_enable_warning, 1'b0);
		m.hold(1'b1, 1'b1, 10);
		// Selection under enable reported as latched error
		do_reset(6'b001110);
		drive_enable = 1'b1;
		m.hold(1'b0, 1'b0, 10);
		chk("err_set", {diag.select_under_enable_warning, diag.select_under_enable_error},
			8'h01);
		drive_enable = 1'b0;
		m.hold(1'b1, 1'b1, 20);
		chk("err_held", {diag.select_under_enable_error, ten_a}, 8'h02);
		clear_pulse();
		chk("err_clear", {diag.select_under_enable_error, ten_a}, 8'h01);
		// Pause too short between two test pulses
		do_reset(6'b000110);
		m.pulse_a(5000);
		m.pulse_a(10);
		chk("width", diag.test_pulse_width_fault, 1'b1);
		chk("logged_width", logged[DG_WIDTH], 1'b1);
		// Forbidden single channel and energise-to-clamp brake
		do_reset(6'b110110);
		chk("cfg_single", {diag.safety_config_fault, ten_a}, 8'h02);
		do_reset(6'b000111);
		chk("cfg_clamp", {diag.safety_config_fault, ten_a}, 8'h02);
		// Allowed single channel selection over A
		do_reset(6'b100110);
		chk("cfg_ok", diag.safety_config_fault, 1'b0);
		m.hold(1'b0, 1'b1, 10);
		chk("single_stop", {ten_a, status.torque_off}, 8'h01);
		m.hold(1'b1, 1'b1, 10);
		// Brake option without a brake, then a brake without the option
		do_reset(6'b000101);
		chk("no_brake", {ten_a, ten_b, brl_a, brl_b, diag.safety_config_fault}, 8'h18);
		m.hold(1'b0, 1'b0, 10);
		chk("no_brake_sel", {status.torque_off, status.brake_active, panel}, 8'h05);
		m.hold(1'b1, 1'b1, 10);
		do_reset(6'b000010);
		chk("no_option", {ten_a, ten_b, brl_a, brl_b}, 8'h0c);
		// Switch-off path stuck energised
		do_reset(6'b000110);
		stuck = 4'h1;
		wt(10300);
		chk("switchoff", diag.switchoff_channel_fault, 1'b1);
		// Deselected with no test pulse
		do_reset(6'b000110);
		wt(16000);
		chk("ivl_miss_ok", diag.test_pulse_interval_fault, 1'b0);
		wt(15000);
		chk("ivl_fault", diag.test_pulse_interval_fault, 1'b1);
		wrap_up();
	end
endmodule
`default_nettype wire
